// ===== verilog/dpzo_seq.sv
// power-down state, calibration engine and termination control of the memory device
`timescale 1ns/1ns
`default_nettype none
module dpzo_seq (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_cke,
  input  wire dpzo_pkg::dpzo_cmd_t      i_cmd,
  input  wire logic                     i_slow_exit,
  input  wire logic                     i_self_refresh,
  input  wire logic                     i_odt,
  input  wire logic [2:0]               i_rtt_nom,
  input  wire logic [1:0]               i_rtt_wr,
  input  wire logic                     i_zq_cmp_drv,
  input  wire logic                     i_zq_cmp_term,
  output logic                          o_low_power_state,
  output logic                          o_cmd_ready,
  output logic                          o_cal_busy,
  output logic                          o_cal_current_en,
  output logic                          o_cal_first_done,
  output logic [dpzo_pkg::CODE_W-1:0]   o_drv_code,
  output logic [dpzo_pkg::CODE_W-1:0]   o_term_code,
  output logic                          o_term_on,
  output logic [2:0]                    o_rtt_nom,
  output logic [1:0]                    o_rtt_wr
);
  import dpzo_pkg::*;

  dpzo_pd_st_t       pd_q;
  dpzo_cal_st_t      cal_q;
  logic              idle_cmd;
  logic              zq_take;
  logic              pd_enter;
  logic              pd_leave;
  logic              exit_exp;
  logic              cal_exp;
  logic [TMR_W-1:0]  exit_len;
  logic [TMR_W-1:0]  cal_len;
  logic [CODE_W-1:0] work_drv_q;
  logic [CODE_W-1:0] work_term_q;
  logic              phase_q;
  logic              short_q;

  assign idle_cmd = (i_cmd == CMD_NOP) || (i_cmd == CMD_DES);
  // entry only from the active state with the calibration engine idle
  assign pd_enter = (pd_q == PD_ACTIVE) && !i_cke && idle_cmd && (cal_q == CAL_IDLE);
  assign pd_leave = (pd_q == PD_LOW) && i_cke && idle_cmd;
  // calibration starts only on an explicit command, never on self-refresh exit
  assign zq_take  = (pd_q == PD_ACTIVE) && i_cke && (cal_q == CAL_IDLE) && o_cmd_ready
                    && ((i_cmd == CMD_ZQCL) || (i_cmd == CMD_ZQCS));
  assign exit_len = i_slow_exit ? XPDLL_NCK : XP_NCK;
  assign cal_len  = (i_cmd == CMD_ZQCS) ? ZQCS_NCK :
                    (o_cal_first_done ? ZQOPER_NCK : ZQINIT_NCK);

  dpzo_timer u_exit_tmr (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_load    (pd_leave),
    .i_value   (exit_len),
    .o_expire  (exit_exp)
  );

  dpzo_timer u_cal_tmr (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_load    (zq_take),
    .i_value   (cal_len),
    .o_expire  (cal_exp)
  );

  // power-down sequencing
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_q              <= PD_ACTIVE;
      o_low_power_state <= 1'b0;
      o_cmd_ready       <= 1'b1;
    end else begin
      case (pd_q)
        PD_ACTIVE: begin
          if (pd_enter) begin
            pd_q              <= PD_LOW;
            o_low_power_state <= 1'b1;
            o_cmd_ready       <= 1'b0;
          end
        end
        PD_LOW: begin
          if (pd_leave) begin
            pd_q              <= PD_EXIT;
            o_low_power_state <= 1'b0;
          end
        end
        PD_EXIT: begin
          if (exit_exp) begin
            pd_q        <= PD_ACTIVE;
            o_cmd_ready <= 1'b1;
          end
        end
        default: begin
          pd_q              <= PD_ACTIVE;
          o_low_power_state <= 1'b0;
          o_cmd_ready       <= 1'b1;
        end
      endcase
    end
  end

  // calibration window control
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_q            <= CAL_IDLE;
      o_cal_busy       <= 1'b0;
      o_cal_current_en <= 1'b0;
      o_cal_first_done <= 1'b0;
      short_q          <= 1'b0;
    end else begin
      case (cal_q)
        CAL_IDLE: begin
          if (zq_take) begin
            cal_q            <= CAL_RUN;
            o_cal_busy       <= 1'b1;
            o_cal_current_en <= 1'b1;
            short_q          <= (i_cmd == CMD_ZQCS);
          end
        end
        CAL_RUN: begin
          if (cal_exp) begin
            cal_q            <= CAL_IDLE;
            o_cal_busy       <= 1'b0;
            o_cal_current_en <= 1'b0;
            if (!short_q) begin
              o_cal_first_done <= 1'b1;
            end
          end
        end
        default: begin
          cal_q            <= CAL_IDLE;
          o_cal_busy       <= 1'b0;
          o_cal_current_en <= 1'b0;
        end
      endcase
    end
  end

  // engine: steps drive code on even cycles, termination code on odd ones
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_drv_q  <= CODE_RST;
      work_term_q <= CODE_RST;
      phase_q     <= 1'b0;
    end else if ((cal_q == CAL_RUN) && !cal_exp) begin
      phase_q <= !phase_q;
      if (!phase_q) begin
        if (i_zq_cmp_drv && (work_drv_q != {CODE_W{1'b1}})) begin
          work_drv_q <= work_drv_q + 1'b1;
        end else if (!i_zq_cmp_drv && (work_drv_q != '0)) begin
          work_drv_q <= work_drv_q - 1'b1;
        end
      end else begin
        if (i_zq_cmp_term && (work_term_q != {CODE_W{1'b1}})) begin
          work_term_q <= work_term_q + 1'b1;
        end else if (!i_zq_cmp_term && (work_term_q != '0)) begin
          work_term_q <= work_term_q - 1'b1;
        end
      end
    end else begin
      phase_q <= 1'b0;
    end
  end

  // transfer of calibrated codes to the I/O at completion only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_drv_code  <= CODE_RST;
      o_term_code <= CODE_RST;
    end else if ((cal_q == CAL_RUN) && cal_exp) begin
      o_drv_code  <= work_drv_q;
      o_term_code <= work_term_q;
    end
  end

  // termination follows the pin, gated by mode bits and self-refresh
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_term_on <= 1'b0;
      o_rtt_nom <= 3'h0;
      o_rtt_wr  <= 2'h0;
    end else begin
      o_term_on <= i_odt && !i_self_refresh && ((|i_rtt_nom) || (|i_rtt_wr));
      o_rtt_nom <= i_rtt_nom;
      o_rtt_wr  <= i_rtt_wr;
    end
  end

  AST_PD_ENTRY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    pd_enter |=> o_low_power_state && !o_cmd_ready)
    else $error("low-power state not entered on CKE low with idle command");

  AST_PD_EXIT_LAT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_leave && !i_slow_exit) |=> !o_low_power_state ##1 !o_cmd_ready[*3] ##1 o_cmd_ready)
    else $error("fast exit latency not honoured");

  AST_PD_SLOW_EXIT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (pd_leave && i_slow_exit) |=> !o_cmd_ready[*8] ##[4:4] o_cmd_ready)
    else $error("slow exit latency not honoured");

  AST_ZQ_START: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    zq_take |=> o_cal_busy && o_cal_current_en)
    else $error("calibration command did not start the engine");

  AST_ZQCS_WINDOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (zq_take && (i_cmd == CMD_ZQCS)) |=> o_cal_busy[*8] ##[58:58] $fell(o_cal_busy))
    else $error("short calibration window is not 65 cycles");

  AST_ZQINIT_LONG: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (zq_take && (i_cmd == CMD_ZQCL) && !o_cal_first_done) |=> ##[300:300] o_cal_busy)
    else $error("first long calibration window too short");

  AST_CURRENT_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(o_cal_busy) |-> !o_cal_current_en && $past(o_cal_current_en))
    else $error("calibration current path left on after completion");

  AST_TRANSFER: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(o_cal_busy) |-> (o_drv_code == $past(work_drv_q)) && (o_term_code == $past(work_term_q)))
    else $error("calibrated codes not transferred at completion");

  AST_CODES_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!o_cal_busy && !$past(o_cal_busy)) |-> $stable(o_drv_code) && $stable(o_term_code))
    else $error("I/O codes changed without a calibration");

  AST_SR_TERM_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_self_refresh |=> !o_term_on)
    else $error("termination on during self-refresh");

  AST_MR_DISABLE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ((i_rtt_nom == 3'h0) && (i_rtt_wr == 2'h0)) |=> !o_term_on)
    else $error("termination on with all mode bits zero");

  AST_ODT_FOLLOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!i_self_refresh && ((|i_rtt_nom) || (|i_rtt_wr))) |=> (o_term_on == $past(i_odt)))
    else $error("termination does not follow the ODT pin");
endmodule
`default_nettype wire

// ===== verilog/dpzo_pkg.sv
// shared constants and types for the power-down, calibration and termination sequencer
// Behaviour
// - CKE low with NOP or deselect enters the low-power state.
// - CKE high with NOP or deselect exits; commands valid after tXP or tXPDLL.
// - Long calibration for initialization, repeatable; each one starts the engine.
// - On completion calibrated drive and termination codes move to the I/O.
// - First long calibration after reset gets tZQinit, later ones tZQoper.
// - Short calibration finishes within tZQCS, 64 clocks, correcting at least 0.5 %; the busy window here lasts 65 clocks.
// - Calibration current path is switched off once calibration is achieved.
// - No self-initiated recalibration on self-refresh exit; only on command.
// - Termination off and ODT input ignored during self-refresh.
// - Termination only if mode register termination bits nonzero; value follows them.
// - ODT low means off, high means on; no command decode used.
package dpzo_pkg;
  localparam int        TMR_W        = 12;
  localparam int        CODE_W       = 4;
  localparam logic [11:0] ZQINIT_NCK = 12'h200;
  localparam logic [11:0] ZQOPER_NCK = 12'h100;
  localparam logic [11:0] ZQCS_NCK   = 12'h040;
  localparam logic [11:0] XP_NCK     = 12'h003;
  localparam logic [11:0] XPDLL_NCK  = 12'h00A;
  localparam logic [3:0]  CODE_RST   = 4'h8;

  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_DES   = 3'h1,
    CMD_ZQCL  = 3'h2,
    CMD_ZQCS  = 3'h3,
    CMD_REF   = 3'h4,
    CMD_OTHER = 3'h5
  } dpzo_cmd_t;

  typedef enum logic [2:0] {
    PD_ACTIVE = 3'b001,
    PD_LOW    = 3'b010,
    PD_EXIT   = 3'b100
  } dpzo_pd_st_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } dpzo_cal_st_t;
endpackage

// ===== verilog/dpzo_timer.sv
// loadable down-counter with a one-cycle expiry pulse
`timescale 1ns/1ns
`default_nettype none
module dpzo_timer
  import dpzo_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic              i_load,
  input  wire logic [TMR_W-1:0]  i_value,
  output logic                   o_expire
);
  logic [TMR_W-1:0] count_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
    end else if (i_load) begin
      count_q <= i_value;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_expire <= 1'b0;
    end else begin
      o_expire <= !i_load && (count_q == {{(TMR_W-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

// ===== tb/dpzo_ctrl_model.sv
// controller-side model driving command, clock enable and termination pins
`timescale 1ns/1ns
`default_nettype none
module dpzo_ctrl_model #(
  parameter int TPD_NCK = 4
) (
  input  wire logic               i_clk_sys,
  output var logic                o_cke,
  output var dpzo_pkg::dpzo_cmd_t o_cmd,
  output var logic                o_odt,
  output var logic                o_slow_exit,
  output var logic                o_self_refresh,
  output var logic [2:0]          o_rtt_nom,
  output var logic [1:0]          o_rtt_wr
);
  import dpzo_pkg::*;
  initial begin
    o_cke = 1'b1;
    o_cmd = CMD_NOP;
    o_odt = 1'b0;
    o_slow_exit = 1'b0;
    o_self_refresh = 1'b0;
    o_rtt_nom = 3'h0;
    o_rtt_wr = 2'h0;
  end
  // one command for one edge, then back to no-operation
  task automatic send(input dpzo_cmd_t c, input logic k);
    @(posedge i_clk_sys);
    o_cmd <= c;
    o_cke <= k;
    @(posedge i_clk_sys);
    o_cmd <= CMD_NOP;
  endtask
  task automatic enter();
    send(CMD_NOP, 1'b0);
  endtask
  task automatic wake(input logic s);
    repeat (TPD_NCK) @(posedge i_clk_sys);
    o_slow_exit <= s;
    send(CMD_NOP, 1'b1);
  endtask
  // termination off and clock enable high before and through calibration
  task automatic calib(input dpzo_cmd_t c);
    @(posedge i_clk_sys);
    o_odt <= 1'b0;
    o_cke <= 1'b1;
    send(c, 1'b1);
  endtask
  task automatic term(input logic o, input logic s, input logic [2:0] n, input logic [1:0] w);
    @(posedge i_clk_sys);
    o_odt <= o;
    o_self_refresh <= s;
    o_rtt_nom <= n;
    o_rtt_wr <= w;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for power-down, calibration and termination
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dpzo_pkg::*;
  logic              i_clk_sys;
  logic              i_rst_n;
  logic              cke, odt, slow, sref, cmp_d, cmp_t;
  logic              lp, rdy, busy, cur, first, ton;
  dpzo_cmd_t         cmd;
  logic [2:0]        nom, nom_q;
  logic [1:0]        wr, wr_q;
  logic [CODE_W-1:0] drv, trm;
  int                err_total, cmp_count, i;
  dpzo_ctrl_model ctl (.i_clk_sys(i_clk_sys), .o_cke(cke), .o_cmd(cmd), .o_odt(odt),
    .o_slow_exit(slow), .o_self_refresh(sref), .o_rtt_nom(nom), .o_rtt_wr(wr));
  dpzo_seq dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cke(cke), .i_cmd(cmd),
    .i_slow_exit(slow), .i_self_refresh(sref), .i_odt(odt), .i_rtt_nom(nom),
    .i_rtt_wr(wr), .i_zq_cmp_drv(cmp_d), .i_zq_cmp_term(cmp_t), .o_low_power_state(lp),
    .o_cmd_ready(rdy), .o_cal_busy(busy), .o_cal_current_en(cur), .o_cal_first_done(first),
    .o_drv_code(drv), .o_term_code(trm), .o_term_on(ton), .o_rtt_nom(nom_q),
    .o_rtt_wr(wr_q));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic do_reset();
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick();
  endtask
  task automatic chk_idle();
    chk_bit("low_power", 1'b0, lp);
    chk_bit("cmd_ready", 1'b1, rdy);
    chk_bit("cal_busy", 1'b0, busy);
    chk_bit("cal_current", 1'b0, cur);
    chk_bit("first_done", 1'b0, first);
    chk_val("drv_code", 12'(CODE_RST), 12'(drv));
    chk_val("term_code", 12'(CODE_RST), 12'(trm));
    chk_bit("term_on", 1'b0, ton);
  endtask
  // counts busy cycles; codes must hold mid-run and land when busy drops
  task automatic cal(input dpzo_cmd_t c, input int n, input logic [3:0] d0, t0, d1, t1);
    int k;
    int cnt;
    cnt = 0;
    ctl.calib(c);
    for (k = 0; k < 1100 && !(cnt > 0 && busy === 1'b0); k++) begin
      tick();
      if (busy === 1'b1) cnt++;
      if (k == 0) chk_bit("busy_rise", 1'b1, busy);
      if (k == 0) chk_bit("current_on", 1'b1, cur);
      if (cnt == 8) chk_val("drv_hold", 12'(d0), 12'(drv));
      if (cnt == 8) chk_val("term_hold", 12'(t0), 12'(trm));
    end
    if (k == 1100) begin
      err_total++;
      end_of_test();
    end
    // the first busy cycle precedes the first sampling tick
    chk_val("busy_cycles", 12'(n), 12'(cnt));
    chk_bit("current_off", 1'b0, cur);
    chk_val("drv_code", 12'(d1), 12'(drv));
    chk_val("term_code", 12'(t1), 12'(trm));
  endtask
  task automatic pd(input logic s, input int l);
    int k;
    ctl.enter();
    tick();
    chk_bit("enter_lp", 1'b1, lp);
    chk_bit("enter_ready", 1'b0, rdy);
    ctl.wake(s);
    for (k = 1; k <= l + 2; k++) begin
      tick();
      if (k == 1) chk_bit("exit_lp", 1'b0, lp);
      if (k == l) chk_bit("exit_latency", 1'b0, rdy);
    end
    chk_bit("exit_ready", 1'b1, rdy);
  endtask
  initial begin
    i_rst_n = 1'b0;
    cmp_d = 1'b1;
    cmp_t = 1'b0;
    err_total = 0;
    cmp_count = 0;
    do_reset();
    chk_idle();
    cal(CMD_ZQCL, int'(ZQINIT_NCK), 4'h8, 4'h8, 4'hF, 4'h0);
    chk_bit("first_done", 1'b1, first);
    cal(CMD_ZQCL, int'(ZQOPER_NCK), 4'hF, 4'h0, 4'hF, 4'h0);
    @(posedge i_clk_sys);
    cmp_d <= 1'b0;
    cmp_t <= 1'b1;
    cal(CMD_ZQCS, int'(ZQCS_NCK), 4'hF, 4'h0, 4'h0, 4'hF);
    pd(1'b0, int'(XP_NCK));
    pd(1'b1, int'(XPDLL_NCK));
    for (i = 0; i < 16; i++) begin
      ctl.term(i[0], i[1], i[2] ? 3'h5 : 3'h0, i[3] ? 2'h2 : 2'h0);
      tick();
      chk_bit("term_on", i[0] & ~i[1] & (i[2] | i[3]), ton);
      chk_val("rtt_nom", i[2] ? 12'h005 : 12'h000, 12'(nom_q));
      chk_val("rtt_wr", i[3] ? 12'h002 : 12'h000, 12'(wr_q));
    end
    ctl.term(1'b0, 1'b0, 3'h0, 2'h0);
    do_reset();
    chk_idle();
    cal(CMD_ZQCL, int'(ZQINIT_NCK), 4'h8, 4'h8, 4'h0, 4'hF);
    end_of_test();
  end
endmodule
`default_nettype wire
